// >>> src/clk_mux_sync.sv
`timescale 1ns/1ps
// Glitch-free source hand-over: stops the old source, waits, then starts the new one.
module clk_mux_sync #(
  parameter int GAP = clk_switch_pkg::SWITCH_GAP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire clk_switch_pkg::clk_src_t want_src,
  input wire logic want_ready,
  output clk_switch_pkg::clk_src_t cur_src,
  output logic gate_on
);
  typedef enum logic [1:0] {ST_RUN, ST_DARK, ST_WAKE} mux_state_t;
  mux_state_t state_reg;
  // The target is latched when the switch starts, so a select that moves during the dark
  // gap cannot pull in a source that was never found ready.
  clk_switch_pkg::clk_src_t target_reg;
  logic [3:0] gap_reg;
  wire change_req = (want_src != cur_src) && want_ready;
  wire gap_done = (gap_reg == 4'(GAP - 1));

  // The gate drops before the source moves, so no shortened pulse reaches the CPU.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_RUN;
      cur_src <= clk_switch_pkg::SRC_INT;
      target_reg <= clk_switch_pkg::SRC_INT;
      gate_on <= 1'b1;
      gap_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (change_req) begin
            gate_on <= 1'b0;
            target_reg <= want_src;
            gap_reg <= 4'h0;
            state_reg <= ST_DARK;
          end
        end
        ST_DARK: begin
          if (gap_done) begin
            cur_src <= target_reg;
            gap_reg <= 4'h0;
            state_reg <= ST_WAKE;
          end else begin
            gap_reg <= gap_reg + 4'h1;
          end
        end
        ST_WAKE: begin
          if (gap_done) begin
            gate_on <= 1'b1;
            state_reg <= ST_RUN;
          end else begin
            gap_reg <= gap_reg + 4'h1;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end
endmodule // clk_mux_sync

// >>> src/clk_switch_pkg.sv
// Register offsets, field positions, reset values, switch gap and clock source codes of the CPU clock switch.
package clk_switch_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CLOCK_OP_MODE = 4'h0;
  localparam logic [3:0] OFF_MAIN_OSC_CTRL = 4'h1;
  localparam logic [3:0] OFF_MAIN_CLK_MODE = 4'h2;
  localparam logic [3:0] OFF_PROC_CLK_CTRL = 4'h3;
  localparam logic [3:0] OFF_INT_OSC_MODE = 4'h4;
  localparam logic [3:0] OFF_OSC_STAB = 4'h5;
  localparam logic [3:0] OFF_CPU_STATUS = 4'h6;
  localparam logic [3:0] OFF_HALT_CMD = 4'h7;
  // Clock operation mode select register fields.
  localparam int BIT_EXT_MAIN_EN = 7;
  localparam int BIT_MAIN_OSC_SEL = 6;
  localparam int BIT_EXT_SUB_EN = 5;
  localparam int BIT_SUB_OSC_SEL = 4;
  localparam int BIT_RANGE_HIGH = 0;
  // Main oscillator control register field.
  localparam int BIT_MAIN_STOP = 7;
  // Main clock mode register fields.
  localparam int BIT_HS_SRC_SEL = 2;
  localparam int BIT_MAIN_SYS_SEL = 0;
  // Processor clock control register fields.
  localparam int BIT_XT_START = 6;
  localparam int BIT_CPU_SUB_SEL = 4;
  // Internal oscillation mode register fields.
  localparam int BIT_INT_STABLE = 7;
  localparam int BIT_INT_STOP = 0;
  localparam logic [7:0] RESET_MAIN_OSC_CTRL = 8'h80;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // Switch pause while the mux is dark, in cycles, spent once before and once after the source change.
  localparam int SWITCH_GAP_CYCLES = 2;
  typedef enum logic [1:0] {SRC_INT, SRC_HIGH, SRC_SUB} clk_src_t;
endpackage

// >>> src/cpu_clock_source_switch.sv
`timescale 1ns/1ps
// CPU clock source selection registers, write-once flags, halt state and source mux control.
module cpu_clock_source_switch (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [clk_switch_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic int_osc_ready,
  input wire logic main_osc_ready,
  input wire logic sub_osc_ready,
  input wire logic [7:0] osc_stab_status,
  input wire logic wake_event,
  output logic main_osc_enable,
  output logic sub_osc_enable,
  output logic int_osc_enable,
  output logic range_high,
  output logic ext_main_input,
  output logic ext_sub_input,
  output logic [1:0] cpu_clk_source,
  output logic cpu_clk_gate,
  output logic cpu_halted
);
  logic [7:0] clock_op_mode_select_reg;
  logic [7:0] main_osc_control_reg;
  logic [7:0] main_clock_mode_reg;
  logic [7:0] processor_clock_ctrl_reg;
  logic [7:0] internal_osc_mode_reg;
  logic range_locked_reg;
  logic hs_locked_reg;
  logic halt_reg;
  logic [7:0] rdata_next;
  clk_switch_pkg::clk_src_t mux_src;
  logic mux_gate;

  function automatic logic hit(input logic [clk_switch_pkg::ADDR_W-1:0] a,
                               input logic [3:0] off);
    hit = (a == off);
  endfunction

  wire wr_mode = wr && hit(addr, clk_switch_pkg::OFF_CLOCK_OP_MODE);
  wire wr_moc = wr && hit(addr, clk_switch_pkg::OFF_MAIN_OSC_CTRL);
  wire wr_mcm = wr && hit(addr, clk_switch_pkg::OFF_MAIN_CLK_MODE);
  wire wr_pcc = wr && hit(addr, clk_switch_pkg::OFF_PROC_CLK_CTRL);
  wire wr_rcm = wr && hit(addr, clk_switch_pkg::OFF_INT_OSC_MODE);
  wire wr_halt = wr && hit(addr, clk_switch_pkg::OFF_HALT_CMD);

  wire range_old = clock_op_mode_select_reg[clk_switch_pkg::BIT_RANGE_HIGH];
  wire range_new = wdata[clk_switch_pkg::BIT_RANGE_HIGH];
  // A changed value consumes the single allowed change; rewriting the same value does not.
  wire range_next = (wr_mode && !range_locked_reg) ? range_new : range_old;
  wire range_used = wr_mode && !range_locked_reg && (range_new != range_old);
  wire hs_old = main_clock_mode_reg[clk_switch_pkg::BIT_HS_SRC_SEL];
  wire hs_new = wdata[clk_switch_pkg::BIT_HS_SRC_SEL];
  wire hs_next = (wr_mcm && !hs_locked_reg) ? hs_new : hs_old;
  wire hs_used = wr_mcm && !hs_locked_reg && (hs_new != hs_old);

  wire main_on = !main_osc_control_reg[clk_switch_pkg::BIT_MAIN_STOP] &&
                 clock_op_mode_select_reg[clk_switch_pkg::BIT_MAIN_OSC_SEL];
  wire sub_xt_on = processor_clock_ctrl_reg[clk_switch_pkg::BIT_XT_START] ||
                   clock_op_mode_select_reg[clk_switch_pkg::BIT_SUB_OSC_SEL];
  wire int_on = !internal_osc_mode_reg[clk_switch_pkg::BIT_INT_STOP];
  wire sub_sel = processor_clock_ctrl_reg[clk_switch_pkg::BIT_CPU_SUB_SEL];
  wire main_sel = main_clock_mode_reg[clk_switch_pkg::BIT_MAIN_SYS_SEL] && hs_old;
  wire ext_main = clock_op_mode_select_reg[clk_switch_pkg::BIT_EXT_MAIN_EN];
  wire ext_sub = clock_op_mode_select_reg[clk_switch_pkg::BIT_EXT_SUB_EN];

  // Subsystem select outranks the main select, which outranks the internal oscillator.
  wire clk_switch_pkg::clk_src_t want_src = sub_sel ? clk_switch_pkg::SRC_SUB :
                                           main_sel ? clk_switch_pkg::SRC_HIGH :
                                           clk_switch_pkg::SRC_INT;
  // An external input counts as ready once enabled; a crystal must report stable.
  wire want_ready = (want_src == clk_switch_pkg::SRC_SUB) ?
                      (sub_xt_on && (ext_sub || sub_osc_ready)) :
                    (want_src == clk_switch_pkg::SRC_HIGH) ?
                      (main_on && (ext_main || main_osc_ready)) :
                      (int_on && int_osc_ready);

  wire int_stable = int_on && int_osc_ready;
  wire [7:0] status_word = {6'h00, 2'(mux_src)};

  // Unmapped offsets and the write-only halt command read as zero.
  assign rdata_next =
    hit(addr, clk_switch_pkg::OFF_CLOCK_OP_MODE) ? clock_op_mode_select_reg :
    hit(addr, clk_switch_pkg::OFF_MAIN_OSC_CTRL) ? main_osc_control_reg :
    hit(addr, clk_switch_pkg::OFF_MAIN_CLK_MODE) ? main_clock_mode_reg :
    hit(addr, clk_switch_pkg::OFF_PROC_CLK_CTRL) ? processor_clock_ctrl_reg :
    hit(addr, clk_switch_pkg::OFF_INT_OSC_MODE) ?
      {int_stable, internal_osc_mode_reg[6:0]} :
    hit(addr, clk_switch_pkg::OFF_OSC_STAB) ? osc_stab_status :
    hit(addr, clk_switch_pkg::OFF_CPU_STATUS) ? status_word :
    8'h00;

  // The mux control owns the dark gap; this block only says where to go and whether it is safe.
  clk_mux_sync #(
    .GAP(clk_switch_pkg::SWITCH_GAP_CYCLES)
  ) u_mux (
    .clk(clk),
    .reset_n(reset_n),
    .want_src(want_src),
    .want_ready(want_ready),
    .cur_src(mux_src),
    .gate_on(mux_gate)
  );

  // Each register has its own short process so that a write strobe touches one place only.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clock_op_mode_select_reg <= clk_switch_pkg::RESET_ZERO;
    end else if (wr_mode) begin
      clock_op_mode_select_reg <= {wdata[7:4], 3'h0, range_next};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_osc_control_reg <= clk_switch_pkg::RESET_MAIN_OSC_CTRL;
    end else if (wr_moc) begin
      main_osc_control_reg <= {wdata[clk_switch_pkg::BIT_MAIN_STOP], 7'h00};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_clock_mode_reg <= clk_switch_pkg::RESET_ZERO;
    end else if (wr_mcm) begin
      main_clock_mode_reg <= {5'h00, hs_next, 1'b0,
                              wdata[clk_switch_pkg::BIT_MAIN_SYS_SEL]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      processor_clock_ctrl_reg <= clk_switch_pkg::RESET_ZERO;
    end else if (wr_pcc) begin
      processor_clock_ctrl_reg <= {1'b0, wdata[clk_switch_pkg::BIT_XT_START], 1'b0,
                                   wdata[clk_switch_pkg::BIT_CPU_SUB_SEL], 4'h0};
    end
  end

  // The internal oscillator may not be stopped while it is the running or chosen source; such a write is dropped.
  wire int_stop_refused = (mux_src == clk_switch_pkg::SRC_INT || want_src == clk_switch_pkg::SRC_INT) &&
                          wdata[clk_switch_pkg::BIT_INT_STOP];
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      internal_osc_mode_reg <= clk_switch_pkg::RESET_ZERO;
    end else if (wr_rcm && !int_stop_refused) begin
      internal_osc_mode_reg <= {7'h00, wdata[clk_switch_pkg::BIT_INT_STOP]};
    end
  end

  // The locks are cleared only by reset, so a second change waits for the next reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      range_locked_reg <= 1'b0;
    end else if (range_used) begin
      range_locked_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hs_locked_reg <= 1'b0;
    end else if (hs_used) begin
      hs_locked_reg <= 1'b1;
    end
  end

  // Halt freezes the CPU clock on the current source; the wake event resumes it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      halt_reg <= 1'b0;
    end else if (wake_event) begin
      halt_reg <= 1'b0;
    end else if (wr_halt) begin
      halt_reg <= 1'b1;
    end
  end

  // Outputs are flops so the oscillator and clock-tree controls never see decode glitches.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 8'h00;
      main_osc_enable <= 1'b0;
      sub_osc_enable <= 1'b0;
      int_osc_enable <= 1'b1;
      range_high <= 1'b0;
      ext_main_input <= 1'b0;
      ext_sub_input <= 1'b0;
      cpu_clk_source <= 2'(clk_switch_pkg::SRC_INT);
      cpu_clk_gate <= 1'b1;
      cpu_halted <= 1'b0;
    end else begin
      rdata <= rd ? rdata_next : 8'h00;
      main_osc_enable <= main_on;
      sub_osc_enable <= sub_xt_on;
      int_osc_enable <= int_on;
      range_high <= range_old;
      ext_main_input <= ext_main;
      ext_sub_input <= ext_sub;
      cpu_clk_source <= 2'(mux_src);
      cpu_clk_gate <= mux_gate && !halt_reg;
      cpu_halted <= halt_reg;
    end
  end
endmodule // cpu_clock_source_switch

// >>> verification/clk_switch_monitor.sv
// Port assertions for the CPU clock source switch.
`timescale 1ns/1ps
module clk_switch_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [clk_switch_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic wake_event,
  input wire logic main_osc_enable,
  input wire logic sub_osc_enable,
  input wire logic int_osc_enable,
  input wire logic range_high,
  input wire logic [1:0] cpu_clk_source,
  input wire logic cpu_clk_gate,
  input wire logic cpu_halted
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire mode_wr = wr && addr == clk_switch_pkg::OFF_CLOCK_OP_MODE;
  wire mode_rd = rd && addr == clk_switch_pkg::OFF_CLOCK_OP_MODE;
  wire ctrl_wr = wr && addr == clk_switch_pkg::OFF_MAIN_OSC_CTRL;
  wire halt_wr = wr && addr == clk_switch_pkg::OFF_HALT_CMD;
  wire [1:0] src = cpu_clk_source;
  reset_src_a: assert property ($rose(reset_n) |->
    src == 2'h0 && cpu_clk_gate && int_osc_enable) else $error("Not internal after reset");
  mode_bits_a: assert property (mode_wr ##1 mode_rd |=>
    rdata[7:4] == $past(wdata[7:4], 2)) else $error("Mode bits read back wrong");
  main_stop_a: assert property (ctrl_wr && wdata[7] ##1 !ctrl_wr |=> !main_osc_enable)
    else $error("Main oscillator not stopped");
  range_once_a: assert property (range_high |=> range_high)
    else $error("Range flag changed twice");
  halt_entry_a: assert property (halt_wr && !wake_event ##1 !wake_event |=>
    cpu_halted && !cpu_clk_gate) else $error("Halt command not taken");
  wake_exit_a: assert property (cpu_halted && wake_event |-> ##[1:2] !cpu_halted)
    else $error("Wake did not end halt");
  // The clock must be dark on both sides of a source change, else the CPU sees a runt pulse.
  switch_dark_a: assert property ($changed(src) |->
    !cpu_clk_gate && !$past(cpu_clk_gate) ##1 !cpu_clk_gate) else $error("Switch not dark");
  switch_ready_a: assert property ($changed(src) |-> (src != 2'h0 || int_osc_enable) &&
    (src != 2'h1 || main_osc_enable) && (src != 2'h2 || sub_osc_enable))
    else $error("Switched to a stopped source");
endmodule // clk_switch_monitor

bind cpu_clock_source_switch clk_switch_monitor u_mon (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .wake_event(wake_event), .main_osc_enable(main_osc_enable),
  .sub_osc_enable(sub_osc_enable), .int_osc_enable(int_osc_enable),
  .range_high(range_high), .cpu_clk_source(cpu_clk_source), .cpu_clk_gate(cpu_clk_gate),
  .cpu_halted(cpu_halted));

// >>> verification/cpu_clock_source_switch_test.sv
// Self-checking bench that walks the CPU clock through every source and halt.
`timescale 1ns/1ps
module cpu_clock_source_switch_test;
  logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, wake = 1'b0;
  logic int_rdy = 1'b1, main_rdy = 1'b0, sub_rdy = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, stab = 8'h00, rdata, m0, v;
  logic main_en, sub_en, int_en, range_high, ext_main, ext_sub, gate, halted;
  logic [1:0] src;
  int num_errors = 0, n_compared = 0, cycles = 0, k;
  always #12.5 clk = ~clk;
  cpu_clock_source_switch u_dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .int_osc_ready(int_rdy), .main_osc_ready(main_rdy),
    .sub_osc_ready(sub_rdy), .osc_stab_status(stab), .wake_event(wake),
    .main_osc_enable(main_en), .sub_osc_enable(sub_en), .int_osc_enable(int_en),
    .range_high(range_high), .ext_main_input(ext_main), .ext_sub_input(ext_sub),
    .cpu_clk_source(src), .cpu_clk_gate(gate), .cpu_halted(halted));
  function automatic logic [1:0] want_src(input logic cpu_sub_clock_select, input logic hs_main);
    return cpu_sub_clock_select ? 2'h2 : hs_main ? 2'h1 : 2'h0;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Callers enter right after a rising edge; a pending strobe drop costs one edge first.
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    if (wr === 1'b1) @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic outs(input logic [7:0] e);
    @(posedge clk);
    #1;
    chk({main_en, sub_en, int_en, range_high, ext_main, ext_sub, gate, halted}, e);
    @(posedge clk);
  endtask
  task automatic wait_src(input logic [1:0] e);
    repeat (40) begin
      @(posedge clk);
      #1;
      if (src === e && gate === 1'b1) break;
    end
    chk({4'h0, src, gate, halted}, {4'h0, e, 2'b10});
    @(posedge clk);
  endtask
  task automatic halt_wake(input logic [1:0] s);
    wreg(clk_switch_pkg::OFF_HALT_CMD, 8'($urandom));
    @(posedge clk);
    #1;
    chk({4'h0, src, gate, halted}, {4'h0, s, 2'b01});
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_src(s);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      $display("ERROR %0t: timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    v = 8'($urandom(32'h41ffabb0));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    outs(8'h22);
    rreg(clk_switch_pkg::OFF_MAIN_OSC_CTRL, 8'h80);
    rreg(clk_switch_pkg::OFF_INT_OSC_MODE, 8'h80);
    stab <= v;
    rreg(clk_switch_pkg::OFF_OSC_STAB, v);
    rreg(4'h8 | 4'($urandom), 8'h00);
    wreg(clk_switch_pkg::OFF_INT_OSC_MODE, 8'h01);
    outs(8'h22);
    halt_wake(2'h0);
    m0 = {1'($urandom), 7'h41};
    wreg(clk_switch_pkg::OFF_CLOCK_OP_MODE, m0);
    rreg(clk_switch_pkg::OFF_CLOCK_OP_MODE, m0);
    wreg(clk_switch_pkg::OFF_CLOCK_OP_MODE, m0 ^ 8'h01);
    rreg(clk_switch_pkg::OFF_CLOCK_OP_MODE, m0);
    wreg(clk_switch_pkg::OFF_MAIN_OSC_CTRL, 8'h00);
    wreg(clk_switch_pkg::OFF_MAIN_CLK_MODE, 8'h05);
    // An external main clock needs no settling wait, so only the crystal case stalls here.
    if (!m0[7]) begin
      outs(8'hb2);
      main_rdy <= 1'b1;
    end
    wait_src(want_src(1'b0, 1'b1));
    outs({4'hb, m0[7], 3'b010});
    wreg(clk_switch_pkg::OFF_MAIN_CLK_MODE, 8'h01);
    rreg(clk_switch_pkg::OFF_MAIN_CLK_MODE, 8'h05);
    halt_wake(2'h1);
    k = $urandom % 3;
    if (k == 0) wreg(clk_switch_pkg::OFF_PROC_CLK_CTRL, 8'h40);
    else wreg(clk_switch_pkg::OFF_CLOCK_OP_MODE, m0 | (k == 2 ? 8'h30 : 8'h10));
    wreg(clk_switch_pkg::OFF_PROC_CLK_CTRL, k == 0 ? 8'h50 : 8'h10);
    if (k != 2) begin
      outs({4'hf, m0[7], 3'b010});
      sub_rdy <= 1'b1;
    end
    wait_src(want_src(1'b1, 1'b1));
    rreg(clk_switch_pkg::OFF_CPU_STATUS, 8'h02);
    halt_wake(2'h2);
    wreg(clk_switch_pkg::OFF_PROC_CLK_CTRL, 8'h00);
    wait_src(want_src(1'b0, 1'b1));
    wreg(clk_switch_pkg::OFF_INT_OSC_MODE, 8'h01);
    int_rdy <= 1'b0;
    rreg(clk_switch_pkg::OFF_INT_OSC_MODE, 8'h01);
    outs({1'b1, k != 0, 2'b01, m0[7], k == 2, 2'b10});
    wreg(clk_switch_pkg::OFF_INT_OSC_MODE, 8'h00);
    int_rdy <= 1'b1;
    wreg(clk_switch_pkg::OFF_MAIN_CLK_MODE, 8'h04);
    wait_src(want_src(1'b0, 1'b0));
    wreg(clk_switch_pkg::OFF_MAIN_OSC_CTRL, 8'h80);
    outs({1'b0, k != 0, 2'b11, m0[7], k == 2, 2'b10});
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    outs(8'h22);
    wreg(clk_switch_pkg::OFF_CLOCK_OP_MODE, 8'h01);
    rreg(clk_switch_pkg::OFF_CLOCK_OP_MODE, 8'h01);
    tally_and_finish();
  end
endmodule // cpu_clock_source_switch_test
